// File: fan_ctl_pkg.sv
// constants, register map and types for the lut fan duty controller
package fan_ctl_pkg;

    // ==========================================================
    // clock and timing
    localparam int CLK_HZ      = 50_000_000;
    localparam int STEP0_US    = 182_000;
    localparam int STEP1_US    = 91_000;
    localparam int STEP2_US    = 46_000;
    localparam int STEP3_US    = 23_000;
    localparam int TACH_REF_HZ = 90_000;
    localparam int TACH_DIV    = CLK_HZ / TACH_REF_HZ;
    localparam int COARSE_HZ   = 360_000;
    localparam int COARSE_DIV  = CLK_HZ / COARSE_HZ;
    localparam int FINE_HZ     = 5_737_500;
    localparam int FINE_DIV    = CLK_HZ / FINE_HZ;
    localparam int SLOW_HZ     = 1_400;
    localparam int SLOW_DIV    = CLK_HZ / SLOW_HZ;

    // ==========================================================
    // sizes
    localparam int LUT_N  = 12;
    localparam int TACH_W = 16;
    localparam int IDX_W  = 8;

    // ==========================================================
    // register indices (byte address is four times the index)
    localparam logic [7:0] IDX_CTRL      = 8'h00;
    localparam logic [7:0] IDX_HYST      = 8'h01;
    localparam logic [7:0] IDX_FREQ      = 8'h02;
    localparam logic [7:0] IDX_STATUS    = 8'h03;
    localparam logic [7:0] IDX_MASK      = 8'h04;
    localparam logic [7:0] IDX_DUTY      = 8'h05;
    localparam logic [7:0] IDX_LEVEL     = 8'h06;
    localparam logic [7:0] IDX_TACH_LOW  = 8'h46;
    localparam logic [7:0] IDX_TACH_HIGH = 8'h47;
    localparam logic [7:0] IDX_LUT_TEMP  = 8'h50;
    localparam logic [7:0] IDX_LUT_DUTY  = 8'h60;

    // ==========================================================
    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] HYST_RST = 8'h01;
    localparam logic [7:0] FREQ_RST = 8'h08;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] LUT_RST  = 8'h00;

    // ==========================================================
    // control fields
    localparam int CTRL_SMOOTH = 0;
    localparam int CTRL_STEP   = 1;
    localparam int CTRL_HALF   = 3;
    localparam int CTRL_FINE   = 4;
    localparam int CTRL_CLKSEL = 5;
    localparam int FREQ_W      = 5;
    localparam logic [4:0] FINE_FREQ = 5'h08;
    localparam logic [7:0] FINE_FULL = 8'hFF;
    localparam int COARSE_SHIFT = 4;

    // ==========================================================
    // status bits
    localparam int ST_TACH  = 0;
    localparam int ST_CRIT  = 1;
    localparam int ST_LEVEL = 2;
    localparam int ST_W     = 3;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic             smooth_en;
        logic [1:0]       step_sel;
        logic             half_deg;
        logic             pwm_fine_res_select;
        logic             pwm_clock_select;
        logic [FREQ_W-1:0] freq;
        logic [7:0]       hyst;
    } cfg_t;

    typedef struct packed {
        logic [TACH_W-1:0] count;
        logic              update;
    } tach_t;

endpackage

// File: fan_ctl_props.sv
// concurrent checks on the fan controller ports
`timescale 1ns/1ps
module fan_ctl_props (
    input wire logic        clock,
    input wire logic        srst,
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic [1:0]  bresp,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0]  rresp,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic        critical_temp_output,
    input wire logic        pwm_out,
    input wire logic        irq
);
    import fan_ctl_pkg::*;
    // ==========================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    chk_crit_full: assert property (critical_temp_output [*4] |-> pwm_out)
        else $error("critical level without full pwm");
    chk_aw_taken: assert property (awvalid && awready |=> !awready)
        else $error("awready high after address taken");
    chk_w_taken: assert property (wvalid && wready |=> !wready)
        else $error("wready high after data taken");
    chk_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    chk_wr_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:3] bvalid)
        else $error("write response late");
    chk_rd_answer: assert property (arvalid && arready |=> rvalid && !arready)
        else $error("read answer missing");
    chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read data dropped early");
    chk_rd_upper: assert property (rvalid |-> rdata[31:8] == 24'h000000)
        else $error("read upper bits nonzero");
    chk_rst_quiet: assert property ($fell(srst) |-> !bvalid && !rvalid && !pwm_out && !irq)
        else $error("outputs active at reset release");
    cover property (critical_temp_output && pwm_out);
    cover property (rvalid && rresp == RESP_SLVERR);
    cover property (irq);
endmodule
bind lut_fan_duty_controller fan_ctl_props props_i (
    .clock, .srst, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .critical_temp_output, .pwm_out, .irq
);

// File: fan_model.sv
// four-pin fan model: spins once driven, two tach pulses per turn
`timescale 1ns/1ps
module fan_model #(
    parameter int HALF_NS = 55_500
)(
    input  wire logic pwm,
    output logic      tach
);
    logic spun;
    initial begin
        spun = 1'b0;
        tach = 1'b1;
    end
    always @(posedge pwm) spun = 1'b1;
    initial begin
        #7;
        forever begin
            #(HALF_NS);
            // pull-up holds the line high while stopped
            if (spun) tach = ~tach;
            else tach = 1'b1;
        end
    end
endmodule

// File: lut_fan_duty_controller.sv
// lut fan duty controller: table lookup, ramp, pwm, tach, axi4-lite registers
`timescale 1ns/1ps

// Function
// - twelve temperature/duty pairs; output duty derived from current temperature
// - smoothing off: duty jumps to the entry's duty on the crossing update
// - smoothing on: duty moves one step per programmed interval toward target
// - fine 1/255 resolution only at the 22.5 khz frequency setting
// - duty holds until temperature exceeds the next entry's set-point
// - comparison in whole or half degrees; half mode triggers half above
// - falling temperature lowers every set-point by the hysteresis amount
// - critical temperature forces full-scale duty immediately, bypassing table and ramp
// - step interval selectable: 0.182, 0.091, 0.046 or 0.023 seconds
// - one interval setting applies to every table transition
// - ramp step is fine 0.39% or coarse 1/16 of full scale (rounded down, at least one count) by resolution mode
// - tach counts 90 khz periods over one revolution of two pulses
// - tach count read as low byte at 46 hex, high at 47
// - duty equals pwm value over full-scale value of the frequency
module lut_fan_duty_controller #(
    parameter int unsigned STEP_CYC_0 = fan_ctl_pkg::STEP0_US * (fan_ctl_pkg::CLK_HZ / 1_000_000),
    parameter int unsigned STEP_CYC_1 = fan_ctl_pkg::STEP1_US * (fan_ctl_pkg::CLK_HZ / 1_000_000),
    parameter int unsigned STEP_CYC_2 = fan_ctl_pkg::STEP2_US * (fan_ctl_pkg::CLK_HZ / 1_000_000),
    parameter int unsigned STEP_CYC_3 = fan_ctl_pkg::STEP3_US * (fan_ctl_pkg::CLK_HZ / 1_000_000),
    parameter int unsigned SLOW_CYC   = fan_ctl_pkg::SLOW_DIV,
    parameter int unsigned AW         = 12
)(
    input  wire logic              clock,
    input  wire logic              srst,
    input  wire logic [AW-1:0]     awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [AW-1:0]     araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    input  wire logic signed [9:0] remote_temp,
    input  wire logic              temp_update,
    input  wire logic              critical_temp_output,
    input  wire logic              tach_in,
    output logic                   pwm_out,
    output logic                   irq
);
    import fan_ctl_pkg::*;

    generate
        if (STEP_CYC_3 < 1 || SLOW_CYC < 2 || AW < IDX_W + 3) begin : g_bad
            $error("unsupported step, divider or address width");
        end
    endgenerate

    // ==========================================================
    // helpers
    function automatic logic [3:0] count_set(input logic [LUT_N-1:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int k = 0; k < LUT_N; k++) begin
            n = n + {3'h0, v[k]};
        end
        return n;
    endfunction

    function automatic logic in_lut(input logic [7:0] idx, input logic [7:0] base);
        return (idx >= base) && (idx < base + 8'(LUT_N));
    endfunction

    function automatic logic reg_mapped(input logic [7:0] idx);
        return idx <= IDX_LEVEL || idx == IDX_TACH_LOW || idx == IDX_TACH_HIGH
            || in_lut(idx, IDX_LUT_TEMP) || in_lut(idx, IDX_LUT_DUTY);
    endfunction

    // ==========================================================
    // state
    logic [7:0]      ctrl_reg;
    logic [7:0]      hyst_reg;
    logic [7:0]      freq_reg;
    logic [7:0]      mask_reg;
    logic [ST_W-1:0] sts_reg;
    logic [7:0]      lut_temp_reg [LUT_N];
    logic [7:0]      lut_duty_reg [LUT_N];
    logic [3:0]      level_reg;
    logic [7:0]      duty_reg;
    logic            crit_d_reg;
    logic [31:0]     step_cnt_reg;
    logic [31:0]     div_cnt_reg;
    logic [7:0]      pcnt_reg;
    logic            aw_got_reg;
    logic            w_got_reg;
    logic [AW-1:0]   waddr_reg;
    logic [7:0]      wbyte_reg;
    logic            wlane_reg;
    tach_t           tach_s;
    cfg_t            cfg;

    assign cfg = '{smooth_en: ctrl_reg[CTRL_SMOOTH], step_sel: ctrl_reg[CTRL_STEP +: 2],
                   half_deg: ctrl_reg[CTRL_HALF], pwm_fine_res_select: ctrl_reg[CTRL_FINE],
                   pwm_clock_select: ctrl_reg[CTRL_CLKSEL], freq: freq_reg[FREQ_W-1:0],
                   hyst: hyst_reg};

    tach_period_counter #(
        .DIV (TACH_DIV),
        .W   (TACH_W)
    ) u_tach (
        .clock   (clock),
        .srst    (srst),
        .tach_in (tach_in),
        .tach    (tach_s)
    );

    // ==========================================================
    // axi write channel
    wire aw_hs   = awvalid && awready;
    wire w_hs    = wvalid && wready;
    wire aw_have = aw_got_reg || aw_hs;
    wire w_have  = w_got_reg || w_hs;
    wire do_wr   = aw_got_reg && w_got_reg && !bvalid;
    wire bv_next = do_wr || (bvalid && !bready);
    wire aw_next = aw_have && !do_wr;
    wire w_next  = w_have && !do_wr;

    wire [7:0] widx   = waddr_reg[IDX_W+1:2];
    wire       w_ok   = (waddr_reg[AW-1:IDX_W+2] == '0) && reg_mapped(widx);
    wire       wr_en  = do_wr && w_ok && wlane_reg;
    wire [7:0] w_offt = widx - IDX_LUT_TEMP;
    wire [7:0] w_offd = widx - IDX_LUT_DUTY;
    wire       w_lutt = wr_en && in_lut(widx, IDX_LUT_TEMP);
    wire       w_lutd = wr_en && in_lut(widx, IDX_LUT_DUTY);
    wire       w_sts  = wr_en && widx == IDX_STATUS;

    always_ff @(posedge clock) begin
        if (srst) begin
            aw_got_reg <= 1'b0;
            w_got_reg  <= 1'b0;
            awready    <= 1'b0;
            wready     <= 1'b0;
            bvalid     <= 1'b0;
            bresp      <= RESP_OKAY;
            waddr_reg  <= '0;
            wbyte_reg  <= 8'h00;
            wlane_reg  <= 1'b0;
        end else begin
            aw_got_reg <= aw_next;
            w_got_reg  <= w_next;
            awready    <= !aw_next && !bv_next;
            wready     <= !w_next && !bv_next;
            bvalid     <= bv_next;
            if (do_wr) bresp <= w_ok ? RESP_OKAY : RESP_SLVERR;
            if (aw_hs) waddr_reg <= awaddr;
            if (w_hs) begin
                wbyte_reg <= wdata[7:0];
                wlane_reg <= wstrb[0];
            end
        end
    end

    // ==========================================================
    // axi read channel
    wire       ar_hs   = arvalid && arready;
    wire       rv_next = ar_hs || (rvalid && !rready);
    wire [7:0] ridx    = araddr[IDX_W+1:2];
    wire       r_ok    = (araddr[AW-1:IDX_W+2] == '0) && reg_mapped(ridx);
    wire [7:0] r_offt  = ridx - IDX_LUT_TEMP;
    wire [7:0] r_offd  = ridx - IDX_LUT_DUTY;
    wire [7:0] r_byte  =
        in_lut(ridx, IDX_LUT_TEMP) ? lut_temp_reg[r_offt[3:0]] :
        in_lut(ridx, IDX_LUT_DUTY) ? lut_duty_reg[r_offd[3:0]] :
        ridx == IDX_CTRL           ? ctrl_reg :
        ridx == IDX_HYST           ? hyst_reg :
        ridx == IDX_FREQ           ? freq_reg :
        ridx == IDX_STATUS         ? {{(8-ST_W){1'b0}}, sts_reg} :
        ridx == IDX_MASK           ? mask_reg :
        ridx == IDX_DUTY           ? duty_reg :
        ridx == IDX_LEVEL          ? {4'h0, level_reg} :
        ridx == IDX_TACH_LOW       ? tach_s.count[7:0] :
        ridx == IDX_TACH_HIGH      ? tach_s.count[15:8] :
                                     8'h00;

    always_ff @(posedge clock) begin
        if (srst) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h0;
            rresp   <= RESP_OKAY;
        end else begin
            arready <= !rv_next;
            rvalid  <= rv_next;
            if (ar_hs) begin
                rdata <= {24'h0, r_ok ? r_byte : 8'h00};
                rresp <= r_ok ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ==========================================================
    // control registers
    always_ff @(posedge clock) begin
        if (srst) begin
            ctrl_reg <= CTRL_RST;
            hyst_reg <= HYST_RST;
            freq_reg <= FREQ_RST;
            mask_reg <= MASK_RST;
        end else if (wr_en) begin
            if (widx == IDX_CTRL) ctrl_reg <= wbyte_reg;
            if (widx == IDX_HYST) hyst_reg <= wbyte_reg;
            if (widx == IDX_FREQ) freq_reg <= wbyte_reg;
            if (widx == IDX_MASK) mask_reg <= wbyte_reg;
        end
    end

    // ==========================================================
    // lookup table and set-point comparison
    logic [LUT_N-1:0] above_up;
    logic [LUT_N-1:0] above_dn;
    wire signed [10:0] temp_x = {remote_temp[9], remote_temp};
    wire signed [10:0] hyst_x = $signed({2'b00, cfg.hyst, 1'b0});
    wire signed [10:0] half_x = cfg.half_deg ? 11'sd1 : 11'sd2;

    genvar g;
    generate
        for (g = 0; g < LUT_N; g++) begin : g_lut
            wire signed [10:0] sp_x = $signed({lut_temp_reg[g][7], lut_temp_reg[g][7], lut_temp_reg[g], 1'b0});
            wire signed [10:0] th   = sp_x + half_x;
            assign above_up[g] = temp_x >= th;
            assign above_dn[g] = temp_x >= th - hyst_x;

            always_ff @(posedge clock) begin
                if (srst) begin
                    lut_temp_reg[g] <= LUT_RST;
                    lut_duty_reg[g] <= LUT_RST;
                end else begin
                    if (w_lutt && w_offt == 8'(g)) lut_temp_reg[g] <= wbyte_reg;
                    if (w_lutd && w_offd == 8'(g)) lut_duty_reg[g] <= wbyte_reg;
                end
            end
        end
    endgenerate

    wire [3:0] up_n       = count_set(above_up);
    wire [3:0] dn_n       = count_set(above_dn);
    wire [3:0] next_level = (up_n >= level_reg) ? up_n :
                            (dn_n < level_reg) ? dn_n : level_reg;
    wire [3:0] lvl_m1     = level_reg - 4'h1;
    wire [7:0] target     = (level_reg == 4'h0) ? 8'h00 : lut_duty_reg[lvl_m1];

    // ==========================================================
    // duty resolution and ramp
    wire       fine_mode = cfg.pwm_fine_res_select && !cfg.pwm_clock_select && cfg.freq == FINE_FREQ;
    wire [7:0] full_w    = fine_mode ? FINE_FULL :
                           (cfg.freq == '0) ? 8'h02 : {2'b00, cfg.freq, 1'b0};
    wire [7:0] coarse_st = full_w >> COARSE_SHIFT;
    wire [7:0] step_w    = fine_mode ? 8'h01 : (coarse_st == 8'h00 ? 8'h01 : coarse_st);
    wire [7:0] tgt       = (target > full_w) ? full_w : target;
    wire [8:0] dsum      = {1'b0, duty_reg} + {1'b0, step_w};
    wire [7:0] ddiff     = duty_reg - tgt;
    wire [7:0] ramp_up   = (dsum >= {1'b0, tgt}) ? tgt : dsum[7:0];
    wire [7:0] ramp_dn   = (ddiff <= step_w) ? tgt : duty_reg - step_w;
    wire [7:0] ramp_next = (duty_reg < tgt) ? ramp_up : (duty_reg > tgt) ? ramp_dn : duty_reg;

    wire [31:0] step_lim = (cfg.step_sel == 2'd0) ? STEP_CYC_0 :
                           (cfg.step_sel == 2'd1) ? STEP_CYC_1 :
                           (cfg.step_sel == 2'd2) ? STEP_CYC_2 : STEP_CYC_3;
    wire        step_tick = step_cnt_reg >= step_lim - 32'h1;

    wire [7:0] duty_next = critical_temp_output ? full_w :
                           !cfg.smooth_en ? tgt :
                           step_tick ? ramp_next : duty_reg;

    always_ff @(posedge clock) begin
        if (srst) begin
            level_reg    <= 4'h0;
            duty_reg     <= 8'h00;
            step_cnt_reg <= 32'h0;
            crit_d_reg   <= 1'b0;
        end else begin
            if (temp_update) level_reg <= next_level;
            duty_reg     <= duty_next;
            step_cnt_reg <= step_tick ? 32'h0 : step_cnt_reg + 32'h1;
            crit_d_reg   <= critical_temp_output;
        end
    end

    // ==========================================================
    // pwm generation
    wire [31:0] div_lim  = fine_mode ? FINE_DIV : cfg.pwm_clock_select ? SLOW_CYC : COARSE_DIV;
    wire        pwm_tick = div_cnt_reg >= div_lim - 32'h1;
    wire [7:0]  pcnt_inc = pcnt_reg + 8'h01;

    always_ff @(posedge clock) begin
        if (srst) begin
            div_cnt_reg <= 32'h0;
            pcnt_reg    <= 8'h00;
            pwm_out     <= 1'b0;
        end else begin
            div_cnt_reg <= pwm_tick ? 32'h0 : div_cnt_reg + 32'h1;
            if (pwm_tick) pcnt_reg <= (pcnt_inc >= full_w) ? 8'h00 : pcnt_inc;
            pwm_out <= pcnt_reg < duty_reg;
        end
    end

    // ==========================================================
    // status and interrupt
    wire [ST_W-1:0] events;
    assign events[ST_TACH]  = tach_s.update;
    assign events[ST_CRIT]  = critical_temp_output && !crit_d_reg;
    assign events[ST_LEVEL] = temp_update && next_level != level_reg;
    wire [ST_W-1:0] clr      = w_sts ? wbyte_reg[ST_W-1:0] : '0;
    wire [ST_W-1:0] sts_next = (sts_reg & ~clr) | events;

    always_ff @(posedge clock) begin
        if (srst) begin
            sts_reg <= '0;
            irq     <= 1'b0;
        end else begin
            sts_reg <= sts_next;
            irq     <= |(sts_next & mask_reg[ST_W-1:0]);
        end
    end
endmodule

// File: tach_period_counter.sv
// tach period counter against the 90 khz reference
`timescale 1ns/1ps
module tach_period_counter #(
    parameter int unsigned DIV = fan_ctl_pkg::TACH_DIV,
    parameter int unsigned W   = fan_ctl_pkg::TACH_W
)(
    input  wire logic                clock,
    input  wire logic                srst,
    input  wire logic                tach_in,
    output fan_ctl_pkg::tach_t       tach
);
    import fan_ctl_pkg::*;

    generate
        if (DIV < 2 || W != TACH_W) begin : g_bad
            $error("tach divider or width unsupported");
        end
    endgenerate

    logic [2:0]   sync_reg;
    logic [31:0]  div_reg;
    logic [W-1:0] cnt_reg;
    logic         half_reg;

    wire ref_tick = (div_reg >= DIV - 1);
    wire rise     = sync_reg[1] && !sync_reg[2];
    wire at_max   = &cnt_reg;

    // ==========================================================
    // sync, reference and counting
    always_ff @(posedge clock) begin
        if (srst) begin
            sync_reg <= 3'h0;
            div_reg  <= 32'h0;
            cnt_reg  <= '0;
            half_reg <= 1'b0;
            tach     <= '0;
        end else begin
            sync_reg    <= {sync_reg[1:0], tach_in};
            div_reg     <= ref_tick ? 32'h0 : div_reg + 32'h1;
            tach.update <= 1'b0;
            if (rise) begin
                half_reg <= !half_reg;
                if (half_reg) begin
                    tach.count  <= cnt_reg;
                    tach.update <= 1'b1;
                    cnt_reg     <= '0;
                end
            end
            if (ref_tick && !at_max && !(rise && half_reg)) begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end
    end
endmodule

// File: tb_top.sv
// self-checking bench for the lut fan duty controller
`timescale 1ns/1ps
module tb_top;
    import fan_ctl_pkg::*;
    logic              clock, srst, awvalid, wvalid, bready, arvalid, rready, temp_update, critical_temp_output;
    logic              awready, wready, bvalid, arready, rvalid, tach_in, pwm_out, irq;
    logic [11:0]       awaddr, araddr;
    logic [31:0]       wdata, rdata;
    logic [3:0]        wstrb;
    logic [1:0]        bresp, rresp, rd_resp, wr_resp;
    logic signed [9:0] remote_temp;
    logic [15:0]       rd_val;
    int                failures, total_checks;
    lut_fan_duty_controller #(.STEP_CYC_0(40), .STEP_CYC_1(30), .STEP_CYC_2(20), .STEP_CYC_3(10),
        .SLOW_CYC(16)) uut (
        .clock, .srst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
        .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .remote_temp,
        .temp_update, .critical_temp_output, .tach_in, .pwm_out, .irq);
    fan_model fan (.pwm(pwm_out), .tach(tach_in));
    // ==========================================================
    // helpers
    task automatic complete_run;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
        total_checks++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            failures++;
            $display("mismatch at %0t: got %h outside %h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        awaddr <= {2'b00, idx, 2'b00};
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        fork
            begin do @(posedge clock); while (!awready); awvalid <= 1'b0; end
            begin do @(posedge clock); while (!wready); wvalid <= 1'b0; end
        join
        do @(posedge clock); while (!bvalid);
        wr_resp = bresp;
        bready <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [7:0] idx);
        araddr <= {2'b00, idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clock); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clock); while (!rvalid);
        rd_val = {8'h00, rdata[7:0]};
        rd_resp = rresp;
        rready <= 1'b0;
        @(posedge clock);
    endtask
    task automatic set_temp(input logic signed [9:0] t);
        remote_temp <= t;
        temp_update <= 1'b1;
        @(posedge clock);
        temp_update <= 1'b0;
        repeat (4) @(posedge clock);
    endtask
    task automatic look(input logic [15:0] d, input logic [15:0] l);
        rd(IDX_DUTY);
        chk(rd_val, d);
        rd(IDX_LEVEL);
        chk(rd_val, l);
    endtask
    task automatic high_count(input int cyc, output logic [15:0] n);
        n = 16'h0000;
        repeat (cyc) begin
            @(posedge clock);
            n = n + 16'(pwm_out);
        end
    endtask
    // ==========================================================
    // scenarios
    task automatic scen_regs;
        rd(IDX_HYST);
        chk(rd_val, 16'(HYST_RST));
        rd(IDX_FREQ);
        chk(rd_val, 16'(FREQ_RST));
        rd(8'h30);
        chk(16'(rd_resp), 16'(RESP_SLVERR));
        wr(8'h30, 8'h55);
        chk(16'(wr_resp), 16'(RESP_SLVERR));
        for (int i = 0; i < LUT_N; i++) begin
            wr(IDX_LUT_TEMP + 8'(i), (i == 0) ? 8'h0A : (i == 1) ? 8'h14 : 8'h64 + 8'(i));
            wr(IDX_LUT_DUTY + 8'(i), (i == 0) ? 8'h04 : (i == 1) ? 8'h09 : 8'h10);
        end
        chk(16'(wr_resp), 16'(RESP_OKAY));
        rd(IDX_LUT_TEMP + 8'h0B);
        chk(rd_val, 16'h006F);
    endtask
    task automatic scen_table;
        logic [15:0] n;
        set_temp(10'sh029);
        look(16'h0004, 16'h0001);
        high_count(2208, n);
        chk_rng(n, 16'h0225, 16'h022B);
        wr(IDX_CTRL, 8'h08);
        set_temp(10'sh029);
        look(16'h0009, 16'h0002);
        set_temp(10'sh028);
        look(16'h0009, 16'h0002);
        set_temp(10'sh026);
        look(16'h0004, 16'h0001);
    endtask
    task automatic scen_crit;
        wr(IDX_MASK, 8'h02);
        critical_temp_output <= 1'b1;
        repeat (4) @(posedge clock);
        chk(16'(pwm_out), 16'h0001);
        rd(IDX_DUTY);
        chk(rd_val, 16'h0010);
        chk(16'(irq), 16'h0001);
        critical_temp_output <= 1'b0;
        wr(IDX_STATUS, 8'h02);
        repeat (3) @(posedge clock);
        chk(16'(irq), 16'h0000);
    endtask
    task automatic scen_tach;
        logic [15:0] lo;
        repeat (25000) @(posedge clock);
        rd(IDX_TACH_LOW);
        lo = rd_val;
        chk_rng(rd_val, 16'h0013, 16'h0015);
        rd(IDX_TACH_HIGH);
        chk(rd_val, 16'h0000);
        chk_rng(16'(5_400_000 / ({rd_val[7:0], lo[7:0]} * 100)), 16'h0A0B, 16'h0B1A);
    endtask
    task automatic scen_smooth;
        logic [15:0] n;
        wr(IDX_CTRL, 8'h1F);
        set_temp(10'sh02A);
        rd(IDX_DUTY);
        chk_rng(rd_val, 16'h0004, 16'h0008);
        repeat (100) @(posedge clock);
        look(16'h0009, 16'h0002);
        high_count(2040, n);
        chk_rng(n, 16'h0046, 16'h004A);
        set_temp(10'sh024);
        repeat (100) @(posedge clock);
        look(16'h0004, 16'h0001);
        wr(IDX_CTRL, 8'h19);
        set_temp(10'sh02A);
        repeat (100) @(posedge clock);
        rd(IDX_DUTY);
        chk_rng(rd_val, 16'h0005, 16'h0008);
        wr(IDX_CTRL, 8'h20);
        high_count(256, n);
        high_count(256, n);
        chk_rng(n, 16'h008E, 16'h0092);
    endtask
    // ==========================================================
    // run
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial begin
        #2_000_000;
        failures++;
        complete_run;
    end
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, temp_update, critical_temp_output} = '0;
        {awaddr, araddr, wdata, remote_temp} = '0;
        wstrb = 4'hF;
        failures = 0;
        total_checks = 0;
        srst = 1'b1;
        repeat (3) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        scen_regs;
        scen_table;
        scen_crit;
        scen_tach;
        scen_smooth;
        complete_run;
    end
endmodule
